// ==== logic/dual_mode_serial_config_port.sv ====
// Dual mode serial configuration port: two-wire and four-wire slaves
// What this block does
// - Select strap low: shared pins act as two-wire clock and data.
// - Two address straps sampled at power-up, each a two bit code.
// - Slave address is 0x0d plus four times strap A plus strap B.
// - Address byte ends in direction bit: zero write, one read.
// - Two-wire pins only pulled low or released, never driven high.
// - Start and stop conditions framed by master and detected here.
// - Nine pulses a byte; receiver pulls data low on the ninth.
// - Write: address, register address, data byte stored at register.
// - Read: address, register, repeated start, read address, data out.
// - Select strap high: shared pins form the four-wire slave port.
// - Each four-wire frame is exactly 17 bits under low select.
// - With select high, data input ignored and output floated.
// - Frame order: direction, address A7 to A0, data D7 to D0.
// - Previous frame shifts out while the current one shifts in.
// - Output driver enabled at once when select falls.
// - Write frames commit on the rising edge of select.
// - Frame bits captured on rising serial clock edges.
// - Read takes two frames; second returns data in last eight bits.
`timescale 1ns/1ps
module dual_mode_serial_config_port (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic mode_sel,
  input wire logic [1:0] slave_address_strap_a,
  input wire logic [1:0] slave_address_strap_b,
  input wire logic scl_sck,
  input wire logic sda_mosi_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic spi_ss_n,
  output logic miso_out,
  output logic miso_oe
);
  import serial_port_pkg::*;

  typedef struct packed {
    logic taken;
    logic [2:0] settle;
    logic spi_mode;
    logic [6:0] slave_addr;
    smb_state_e st;
    smb_state_e after;
    logic [7:0] sh;
    logic [3:0] bits;
    logic [7:0] ptr;
    logic sda_oe;
    logic scl_q;
    logic sda_q;
    logic ss_q;
    logic [16:0] reply;
  } port_s;

  port_s s_ff;
  port_s nxt_s;

  logic [7:0] mem [REG_COUNT];
  logic we;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] rd_ptr;
  logic [7:0] rd_frame;

  logic scl_lvl;
  logic sda_lvl;
  logic ss_lvl;
  logic mode_lvl;
  logic strap_a1_lvl;
  logic strap_a0_lvl;
  logic strap_b1_lvl;
  logic strap_b0_lvl;
  logic [16:0] frame;
  logic [4:0] frame_bits;
  logic spi_miso;

  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;
  logic ss_rise;
  logic smb_on;
  logic spi_on;

  // Slave address from the two strap codes
  function automatic logic [6:0] slave_addr_of(input logic [1:0] a,
                                               input logic [1:0] b);
    logic [6:0] sum;
    sum = SLAVE_ADDR_BASE + 7'(a) * 7'(STRAP_A_WEIGHT) + 7'(b);
    return sum;
  endfunction

  // Pin inputs into the reference clock domain
  pin_sync #(.RESET_LEVEL(PIN_IDLE_HIGH)) u_scl_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin(scl_sck),
    .level(scl_lvl)
  );

  pin_sync #(.RESET_LEVEL(PIN_IDLE_HIGH)) u_sda_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin(sda_mosi_in),
    .level(sda_lvl)
  );

  pin_sync #(.RESET_LEVEL(PIN_IDLE_HIGH)) u_ss_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin(spi_ss_n),
    .level(ss_lvl)
  );

  // Strap pins pass the same filter before they are caught
  pin_sync u_mode_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin(mode_sel),
    .level(mode_lvl)
  );
  pin_sync u_strap_a1_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin(slave_address_strap_a[1]),
    .level(strap_a1_lvl)
  );
  pin_sync u_strap_a0_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin(slave_address_strap_a[0]),
    .level(strap_a0_lvl)
  );
  pin_sync u_strap_b1_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin(slave_address_strap_b[1]),
    .level(strap_b1_lvl)
  );
  pin_sync u_strap_b0_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin(slave_address_strap_b[0]),
    .level(strap_b0_lvl)
  );

  // Four-wire shift register on the serial clock
  spi_frame_shifter u_shifter (
    .spi_sck(scl_sck),
    .spi_ss_n(spi_ss_n),
    .mosi(sda_mosi_in),
    .reply(s_ff.reply),
    .frame(frame),
    .frame_bits(frame_bits),
    .miso(spi_miso)
  );

  // Register space reads
  assign rd_ptr = mem[s_ff.ptr];
  assign rd_frame = mem[frame[15:8]];

  // Line events from filtered levels
  assign scl_rise = scl_lvl && !s_ff.scl_q;
  assign scl_fall = !scl_lvl && s_ff.scl_q;
  assign start_evt = scl_lvl && s_ff.scl_q && s_ff.sda_q && !sda_lvl;
  assign stop_evt = scl_lvl && s_ff.scl_q && !s_ff.sda_q && sda_lvl;
  assign ss_rise = ss_lvl && !s_ff.ss_q;
  assign smb_on = s_ff.taken && (s_ff.spi_mode == MODE_SEL_SMBUS);
  assign spi_on = s_ff.taken && (s_ff.spi_mode == MODE_SEL_SPI);

  // Next state of both slaves
  always_comb begin
    nxt_s = s_ff;
    we = 1'b0;
    waddr = s_ff.ptr;
    wdata = s_ff.sh;
    nxt_s.scl_q = scl_lvl;
    nxt_s.sda_q = sda_lvl;
    nxt_s.ss_q = ss_lvl;
    // Straps caught once, after their synchronisers have settled
    if (!s_ff.taken) begin
      if (s_ff.settle != STRAP_SETTLE_CYCLES) begin
        nxt_s.settle = s_ff.settle + 3'h1;
      end else begin
        nxt_s.taken = 1'b1;
        nxt_s.spi_mode = mode_lvl;
        nxt_s.slave_addr = slave_addr_of({strap_a1_lvl, strap_a0_lvl},
                                         {strap_b1_lvl, strap_b0_lvl});
      end
    end
    // Two-wire slave
    if (smb_on) begin
      if (start_evt) begin
        nxt_s.st = SMB_ADDR;
        nxt_s.bits = 4'h0;
        nxt_s.sda_oe = 1'b0;
      end else if (stop_evt) begin
        nxt_s.st = SMB_IDLE;
        nxt_s.sda_oe = 1'b0;
      end else begin
        unique case (s_ff.st)
          SMB_IDLE: begin
            nxt_s.sda_oe = 1'b0;
          end
          SMB_ADDR, SMB_REG, SMB_WDATA: begin
            if (scl_rise && (s_ff.bits < BYTE_BITS)) begin
              nxt_s.sh = {s_ff.sh[6:0], sda_lvl};
              nxt_s.bits = s_ff.bits + 4'h1;
            end else if (scl_fall && (s_ff.bits == BYTE_BITS)) begin
              nxt_s.st = SMB_ACK;
              nxt_s.sda_oe = 1'b1;
              if (s_ff.st == SMB_ADDR) begin
                if (s_ff.sh[7:1] != s_ff.slave_addr) begin
                  nxt_s.st = SMB_IDLE;
                  nxt_s.sda_oe = 1'b0;
                end else if (s_ff.sh[0] == FRAME_DIR_READ) begin
                  nxt_s.after = SMB_RDATA;
                end else begin
                  nxt_s.after = SMB_REG;
                end
              end else if (s_ff.st == SMB_REG) begin
                nxt_s.ptr = s_ff.sh;
                nxt_s.after = SMB_WDATA;
              end else begin
                we = 1'b1;
                nxt_s.ptr = s_ff.ptr + 8'h01;
                nxt_s.after = SMB_WDATA;
              end
            end
          end
          SMB_ACK: begin
            if (scl_fall) begin
              nxt_s.sda_oe = 1'b0;
              nxt_s.bits = 4'h0;
              if (s_ff.after == SMB_RDATA) begin
                nxt_s.sh = rd_ptr;
                nxt_s.ptr = s_ff.ptr + 8'h01;
                nxt_s.sda_oe = !rd_ptr[7];
                nxt_s.st = SMB_RDATA;
              end else begin
                nxt_s.st = s_ff.after;
              end
            end
          end
          SMB_RDATA: begin
            if (scl_fall) begin
              if (s_ff.bits == LAST_DATA_BIT) begin
                nxt_s.sda_oe = 1'b0;
                nxt_s.st = SMB_RACK;
              end else begin
                nxt_s.sh = {s_ff.sh[6:0], 1'b0};
                nxt_s.bits = s_ff.bits + 4'h1;
                nxt_s.sda_oe = !s_ff.sh[6];
              end
            end
          end
          SMB_RACK: begin
            if (scl_rise) begin
              if (sda_lvl) begin
                nxt_s.st = SMB_IDLE;
              end else begin
                nxt_s.st = SMB_ACK;
                nxt_s.after = SMB_RDATA;
              end
            end
          end
        endcase
      end
    end
    // Four-wire commit when select rises
    if (spi_on && ss_rise && (frame_bits == FRAME_BITS)) begin
      if (frame[FRAME_DIR_POS] != FRAME_DIR_READ) begin
        we = 1'b1;
        waddr = frame[15:8];
        wdata = frame[7:0];
        nxt_s.reply = frame;
      end else begin
        nxt_s.reply = {FRAME_DIR_READ, frame[15:8], rd_frame};
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_ff <= '{taken: 1'b0, settle: 3'h0, spi_mode: MODE_SEL_SMBUS,
                slave_addr: SLAVE_ADDR_BASE, st: SMB_IDLE, after: SMB_IDLE,
                sh: REG_RESET_VALUE, bits: 4'h0,
                ptr: REG_RESET_VALUE, sda_oe: 1'b0, scl_q: PIN_IDLE_HIGH,
                sda_q: PIN_IDLE_HIGH, ss_q: PIN_IDLE_HIGH,
                reply: FRAME_RESET_VALUE};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Shared register space
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        mem[i] <= REG_RESET_VALUE;
      end
    end else if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Open drain data line, select gated output driver
  assign sda_out = 1'b0;
  assign sda_oe = s_ff.sda_oe;
  assign miso_out = spi_miso;
  assign miso_oe = !spi_ss_n && s_ff.spi_mode && s_ff.taken;

  // Checks
  a_addr_strap: assert property (@(posedge ref_clk) disable iff (srst)
    s_ff.taken && !$past(s_ff.taken) |-> s_ff.slave_addr == SLAVE_ADDR_BASE
    + 7'({$past(slave_address_strap_a), 2'b00}) + 7'($past(slave_address_strap_b)))
    else $error("slave address does not follow straps");
  a_mode_held: assert property (@(posedge ref_clk) disable iff (srst)
    s_ff.taken && $past(s_ff.taken) |-> $stable(s_ff.spi_mode))
    else $error("mode changed after strap capture");
  a_spi_no_sda: assert property (@(posedge ref_clk) disable iff (srst)
    spi_on |-> !s_ff.sda_oe && (s_ff.st == SMB_IDLE))
    else $error("two-wire slave active in four-wire mode");
  a_start_addr: assert property (@(posedge ref_clk) disable iff (srst)
    smb_on && start_evt |=> (s_ff.st == SMB_ADDR) && (s_ff.bits == 4'h0))
    else $error("start not followed by address phase");
  a_stop_idle: assert property (@(posedge ref_clk) disable iff (srst)
    smb_on && stop_evt && !start_evt |=> (s_ff.st == SMB_IDLE) && !s_ff.sda_oe)
    else $error("stop did not return slave to idle");
  a_addr_ack: assert property (@(posedge ref_clk) disable iff (srst)
    smb_on && !start_evt && !stop_evt && (s_ff.st == SMB_ADDR) && scl_fall
    && (s_ff.bits == 4'h8) && (s_ff.sh[7:1] == s_ff.slave_addr) |=> s_ff.sda_oe)
    else $error("matching address not acknowledged");
  a_idle_release: assert property (@(posedge ref_clk) disable iff (srst)
    s_ff.st == SMB_IDLE |-> !s_ff.sda_oe)
    else $error("data line pulled low while idle");
  a_spi_commit: assert property (@(posedge ref_clk) disable iff (srst)
    spi_on && ss_rise && (frame_bits == FRAME_BITS) && !frame[FRAME_DIR_POS]
    |=> mem[$past(frame[15:8])] == $past(frame[7:0]))
    else $error("write frame not committed on select rise");
  a_spi_read: assert property (@(posedge ref_clk) disable iff (srst)
    spi_on && ss_rise && (frame_bits == FRAME_BITS) && frame[FRAME_DIR_POS]
    |=> s_ff.reply[7:0] == $past(rd_frame) && s_ff.reply[15:8] == $past(frame[15:8]))
    else $error("read reply not loaded");
  a_bad_length: assert property (@(posedge ref_clk) disable iff (srst)
    spi_on && ss_rise && (frame_bits != FRAME_BITS) |=> $stable(s_ff.reply))
    else $error("short or long frame acted upon");

  c_smb_write: cover property (@(posedge ref_clk) disable iff (srst)
    smb_on && we && (s_ff.st == SMB_WDATA));
  c_smb_read: cover property (@(posedge ref_clk) disable iff (srst)
    s_ff.st == SMB_RACK ##1 s_ff.st == SMB_ACK);
  c_spi_write: cover property (@(posedge ref_clk) disable iff (srst)
    spi_on && we);
  c_spi_read: cover property (@(posedge ref_clk) disable iff (srst)
    spi_on && ss_rise && (frame_bits == FRAME_BITS) && frame[FRAME_DIR_POS]);
endmodule

// ==== include/serial_port_pkg.sv ====
// Shared constants and types for the dual mode serial configuration port
package serial_port_pkg;

  // Register space
  localparam int REG_ADDR_W = 8;
  localparam int REG_DATA_W = 8;
  localparam int REG_COUNT = 256;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;

  // Two-wire slave addressing
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h0d;
  localparam logic [2:0] STRAP_A_WEIGHT = 3'h4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;

  // Four-level strap codes
  localparam logic [1:0] STRAP_STRONG_LOW = 2'h0;
  localparam logic [1:0] STRAP_WEAK_LOW = 2'h1;
  localparam logic [1:0] STRAP_FLOAT = 2'h2;
  localparam logic [1:0] STRAP_PULL_UP = 2'h3;

  // Interface select strap level
  localparam logic MODE_SEL_SMBUS = 1'b0;
  localparam logic MODE_SEL_SPI = 1'b1;

  // Serial frame layout
  localparam logic [4:0] FRAME_BITS = 5'h11;
  localparam logic [4:0] FRAME_BITS_MAX = 5'h1f;
  localparam int FRAME_DIR_POS = 16;
  localparam int FRAME_ADDR_LSB = 8;
  localparam logic FRAME_DIR_READ = 1'b1;
  localparam logic [16:0] FRAME_RESET_VALUE = 17'h00000;

  // Synchroniser idle levels
  localparam logic PIN_IDLE_HIGH = 1'b1;

  // Cycles after reset before the strap synchronisers show the pin levels
  localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h4;

  // Two-wire slave states
  typedef enum logic [2:0] {
    SMB_IDLE,
    SMB_ADDR,
    SMB_REG,
    SMB_WDATA,
    SMB_ACK,
    SMB_RDATA,
    SMB_RACK
  } smb_state_e;

endpackage

// ==== logic/pin_sync.sv ====
// Three flop input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic pin,
  output logic level
);
  import serial_port_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_s;

  sync_s s_ff;
  sync_s nxt_s;

  // Level changes only when the second and third stages agree
  always_comb begin
    nxt_s = s_ff;
    nxt_s.s1 = pin;
    nxt_s.s2 = s_ff.s1;
    nxt_s.s3 = s_ff.s2;
    if (s_ff.s2 == s_ff.s3) begin
      nxt_s.lvl = s_ff.s3;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_ff <= {4{RESET_LEVEL}};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign level = s_ff.lvl;
endmodule

// ==== logic/spi_frame_shifter.sv ====
// Serial clock domain shift register of the four-wire port
`timescale 1ns/1ps
module spi_frame_shifter (
  input wire logic spi_sck,
  input wire logic spi_ss_n,
  input wire logic mosi,
  input wire logic [16:0] reply,
  output logic [16:0] frame,
  output logic [4:0] frame_bits,
  output logic miso
);
  import serial_port_pkg::*;

  typedef struct packed {
    logic [16:0] shreg;
    logic [4:0] cnt;
  } shift_s;

  shift_s s_ff;
  shift_s nxt_s;
  logic fresh_ff;

  // Marks a new frame; preset while select is high
  always_ff @(posedge spi_sck or posedge spi_ss_n) begin
    if (spi_ss_n) begin
      fresh_ff <= 1'b1;
    end else begin
      fresh_ff <= 1'b0;
    end
  end

  // First edge loads the reply word, later edges shift
  always_comb begin
    nxt_s = s_ff;
    if (!spi_ss_n) begin
      if (fresh_ff) begin
        nxt_s.shreg = {reply[15:0], mosi};
        nxt_s.cnt = 5'h01;
      end else begin
        nxt_s.shreg = {s_ff.shreg[15:0], mosi};
        if (s_ff.cnt != FRAME_BITS_MAX) begin
          nxt_s.cnt = s_ff.cnt + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge spi_sck) begin
    s_ff <= nxt_s;
  end

  assign frame = s_ff.shreg;
  assign frame_bits = s_ff.cnt;
  // Reply MSB stands before the first edge
  assign miso = fresh_ff ? reply[16] : s_ff.shreg[16];

  a_first_load: assert property (@(posedge spi_sck) disable iff (spi_ss_n)
    fresh_ff |=> (s_ff.cnt == 5'h01) && (s_ff.shreg[16:1] == $past(reply[15:0])))
    else $error("first edge did not load reply word");
  a_shift_order: assert property (@(posedge spi_sck) disable iff (spi_ss_n)
    !fresh_ff |=> s_ff.shreg[16:1] == $past(s_ff.shreg[15:0]))
    else $error("frame bits not shifted in order");
endmodule

// ==== testbench/serial_host_model.sv ====
// Host controller model for the two-wire and four-wire serial ports
`timescale 1ns/1ps
module serial_host_model (
  input wire logic data_line,
  input wire logic miso_line,
  output logic clk_pin,
  output logic data_pin,
  output logic ss_n
);
  localparam int QTR = 625; // Quarter of a 2.5 us bit, 400 kHz
  localparam int SCK_HALF = 16; // 32 ns serial clock period

  // Idle levels at time zero
  initial begin
    clk_pin = 1'b1;
    data_pin = 1'b1;
    ss_n = 1'b1;
  end

  // Start or repeated start: data falls while clock high
  task automatic smb_start();
    data_pin = 1'b1;
    #QTR;
    clk_pin = 1'b1;
    #QTR;
    data_pin = 1'b0;
    #QTR;
    clk_pin = 1'b0;
    #QTR;
  endtask

  // Stop: data rises while clock high
  task automatic smb_stop();
    data_pin = 1'b0;
    #QTR;
    clk_pin = 1'b1;
    #QTR;
    data_pin = 1'b1;
    #QTR;
  endtask

  // One clock pulse, data set while clock low
  task automatic smb_bit(input logic tx, output logic rx);
    data_pin = tx;
    #QTR;
    clk_pin = 1'b1;
    #QTR;
    rx = data_line;
    #QTR;
    clk_pin = 1'b0;
    #QTR;
  endtask

  // Eight bits MSB first, then the acknowledge pulse
  task automatic smb_byte(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
      output logic ack_rx);
    for (int i = 7; i >= 0; i--) begin
      smb_bit(tx[i], rx[i]);
    end
    smb_bit(ack_tx, ack_rx); // Release to listen, or nack the last read
  endtask

  // Frame under low select, each bit valid at the rising clock
  task automatic spi_frame(input logic [16:0] tx, input int nbits, output logic [16:0] rx);
    clk_pin = 1'b0;
    #3;
    ss_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      data_pin = tx[16 - i];
      #SCK_HALF;
      rx[16 - i] = miso_line;
      clk_pin = 1'b1;
      #SCK_HALF;
      clk_pin = 1'b0;
    end
    #SCK_HALF;
    ss_n = 1'b1;
    data_pin = ~data_pin; // Released line no longer holds the last bit
    #200;
  endtask
endmodule

// ==== testbench/test_dual_mode_serial_config_port.sv ====
// Self-checking bench for the dual mode serial configuration port
`timescale 1ns/1ps
module test_dual_mode_serial_config_port;
  import serial_port_pkg::*;
  localparam int LIMIT = 90000;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic mode_sel = MODE_SEL_SPI;
  logic [1:0] strap_a = 2'h0;
  logic [1:0] strap_b = 2'h0;
  logic clk_pin, data_pin, ss_n, sda_in, sda_out, sda_oe, miso_out, miso_oe;
  logic miso_hold = 1'b0;
  logic miso_line, spi_on = 1'b0, sda_seen = 1'b0;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  // Pull-up on the data line, open-drain pulls from both sides
  assign sda_in = data_pin & ~sda_oe;
  assign miso_line = miso_oe ? miso_out : ~miso_hold;

  dual_mode_serial_config_port u_dual_mode_serial_config_port (
    .ref_clk(ref_clk),
    .srst(srst),
    .mode_sel(mode_sel),
    .slave_address_strap_a(strap_a),
    .slave_address_strap_b(strap_b),
    .scl_sck(clk_pin),
    .sda_mosi_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .spi_ss_n(ss_n),
    .miso_out(miso_out),
    .miso_oe(miso_oe)
  );

  serial_host_model u_serial_host_model (
    .data_line(sda_in),
    .miso_line(miso_line),
    .clk_pin(clk_pin),
    .data_pin(data_pin),
    .ss_n(ss_n)
  );

  // Clock and hang guard
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (miso_oe) miso_hold <= miso_out;
    if (spi_on && sda_oe) sda_seen <= 1'b1;
    if (cycles == LIMIT) begin
      num_errors++;
      conclude();
    end
  end

  // Output enable follows select at once in four-wire mode
  always @(negedge ss_n) begin
    #1;
    if (spi_on) check("miso_oe select low", 17'h1, 17'(miso_oe));
  end
  always @(posedge ss_n) begin
    #1;
    if (spi_on) check("miso_oe select high", 17'h0, 17'(miso_oe));
  end

  task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Reset for 16 cycles with the given straps
  task automatic reset_dut(input logic mode, input logic [1:0] a, input logic [1:0] b);
    @(posedge ref_clk);
    #1;
    srst = 1'b1;
    mode_sel = mode;
    strap_a = a;
    strap_b = b;
    repeat (16) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  // Read frame then dummy frame, data in last eight bits
  task automatic spi_read(input logic [7:0] addr, input logic [7:0] exp);
    logic [16:0] rx;
    u_serial_host_model.spi_frame({FRAME_DIR_READ, addr, 8'hff}, 17, rx);
    u_serial_host_model.spi_frame({FRAME_DIR_READ, 8'hff, 8'hff}, 17, rx);
    check("spi read reply", {FRAME_DIR_READ, addr, exp}, rx);
  endtask

  // Back-to-back writes, previous frame comes back out
  task automatic spi_write_reply();
    logic [16:0] rx;
    u_serial_host_model.spi_frame({1'b0, 8'h5a, 8'hc3}, 17, rx);
    u_serial_host_model.spi_frame({1'b0, 8'h11, 8'h7e}, 17, rx);
    check("spi reply after write", {1'b0, 8'h5a, 8'hc3}, rx);
    spi_read(8'h5a, 8'hc3);
    spi_read(8'h11, 8'h7e);
  endtask

  // A 16 bit frame must not write
  task automatic spi_short_frame();
    logic [16:0] rx;
    u_serial_host_model.spi_frame({1'b0, 8'h5a, 8'h00}, 16, rx);
    spi_read(8'h5a, 8'hc3);
  endtask

  // Every strap pair answers at its own address
  task automatic smb_address_straps();
    logic [7:0] rx;
    logic ack;
    logic [6:0] addr;
    for (int a = 0; a < 4; a++) begin
      for (int b = 0; b < 4; b++) begin
        reset_dut(MODE_SEL_SMBUS, 2'(a), 2'(b));
        addr = 7'(int'(SLAVE_ADDR_BASE) + int'(STRAP_A_WEIGHT) * a + b);
        u_serial_host_model.smb_start();
        u_serial_host_model.smb_byte({addr, 1'b0}, 1'b1, rx, ack);
        check("strap address ack", 17'h0, 17'(ack));
        u_serial_host_model.smb_stop();
      end
    end
  endtask

  // Foreign address refused, then a two byte write
  task automatic smb_write_burst();
    logic [7:0] rx;
    logic ack;
    u_serial_host_model.smb_start();
    u_serial_host_model.smb_byte({7'h1b, 1'b0}, 1'b1, rx, ack);
    check("foreign address nack", 17'h1, 17'(ack));
    u_serial_host_model.smb_stop();
    u_serial_host_model.smb_start();
    u_serial_host_model.smb_byte({7'h1c, 1'b0}, 1'b1, rx, ack);
    check("write address ack", 17'h0, 17'(ack));
    check("open drain value", 17'h0, 17'(sda_out));
    u_serial_host_model.smb_byte(8'h40, 1'b1, rx, ack);
    check("register ack", 17'h0, 17'(ack));
    u_serial_host_model.smb_byte(8'h9b, 1'b1, rx, ack);
    check("data ack", 17'h0, 17'(ack));
    u_serial_host_model.smb_byte(8'h37, 1'b1, rx, ack);
    u_serial_host_model.smb_stop();
  endtask

  // Repeated start read of two bytes, nack on the last
  task automatic smb_read_burst();
    logic [7:0] rx;
    logic ack;
    u_serial_host_model.smb_start();
    u_serial_host_model.smb_byte({7'h1c, 1'b0}, 1'b1, rx, ack);
    u_serial_host_model.smb_byte(8'h40, 1'b1, rx, ack);
    u_serial_host_model.smb_start();
    u_serial_host_model.smb_byte({7'h1c, 1'b1}, 1'b1, rx, ack);
    check("read address ack", 17'h0, 17'(ack));
    u_serial_host_model.smb_byte(8'hff, 1'b0, rx, ack);
    check("first read byte", 17'h9b, 17'(rx));
    u_serial_host_model.smb_byte(8'hff, 1'b1, rx, ack);
    check("second read byte", 17'h37, 17'(rx));
    u_serial_host_model.smb_stop();
  endtask

  // Main sequence: four-wire mode, then two-wire mode
  initial begin
    reset_dut(MODE_SEL_SPI, 2'h0, 2'h0);
    spi_on = 1'b1;
    spi_write_reply();
    spi_short_frame();
    spi_on = 1'b0;
    check("two-wire idle in spi mode", 17'h0, 17'(sda_seen));
    smb_address_straps();
    smb_write_burst();
    smb_read_burst();
    conclude();
  end
endmodule
